// [pkg/ddr2_cfg_params.svh]
`ifndef DDR2_CFG_PARAMS_SVH
`define DDR2_CFG_PARAMS_SVH
// register byte offsets on the apb side
`define OFF_MODE  8'h00
`define OFF_EXT1  8'h04
`define OFF_EXT2  8'h08
`define OFF_EXT3  8'h0c
`define OFF_STAT  8'h10
`define OFF_CTRL  8'h14
// reset values
`define MODE_RST  14'h0000
`define EXT_RST   14'h0000
`define CTRL_RST  1'b1
// main mode word fields
`define BL_LSB    0
`define CL_LSB    4
`define TM_BIT    7
`define DLLR_BIT  8
`define WR_LSB    9
`define PD_BIT    12
// first extended word fields
`define DLL_BIT   0
`define DRV_BIT   1
`define TRM0_BIT  2
`define AL_LSB    3
`define TRM1_BIT  6
`define DQSN_BIT  10
`define RDQS_BIT  11
`define QOFF_BIT  12
// timing in clocks
`define DLL_LOCK_CLKS 8'd200
`endif

// [pkg/ddr2_cfg_pkg.sv]
package ddr2_cfg_pkg;
    // decoded command seen on the command pins
    typedef enum logic [3:0] {
        CMD_NONE, CMD_LOAD, CMD_REF, CMD_PRE, CMD_ACT, CMD_WR, CMD_WRA,
        CMD_RD, CMD_RDA, CMD_SRE, CMD_PDE, CMD_EXIT
    } cmd_t;
    // power state of the device
    typedef enum logic [1:0] {
        PWR_ACTIVE, PWR_ACT_PD, PWR_PRE_PD, PWR_SELF_REF
    } pwr_t;
endpackage

// [verilog/pin_sync.sv]
`timescale 1ns/1ns
// two-stage synchroniser for a bundle of pins
module pin_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // pins in, synchronised out
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    // the first stage feeds only the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= d;
            sync_q <= meta_q;
        end
    end

    assign q = sync_q;
endmodule

// [verilog/ddr2_mode_register_config.sv]
`timescale 1ns/1ns
`include "ddr2_cfg_params.svh"

// What the document asks of this block and of its controller
// [RULE1] main bit 7 set enters test mode; other main fields stay unchanged
// [RULE2] main bit 8 fires a dll reset and never stays stored
// [RULE3] controller waits 200 clocks after dll reset before a read
// [RULE4] auto-precharge write precharges write-recovery clocks after last data
// [RULE5] write-recovery field only codes 2 to 6 clocks
// [RULE6] controller rounds write recovery time over clock period upward
// [RULE7] bit 12 low gives fast-exit active power-down, dll running
// [RULE8] bit 12 high gives slow-exit active power-down, dll frozen
// [RULE9] cas latency field selects 3 to 6 whole clocks; code 7 here gives 7 clocks
// [RULE10] read at edge n, latency m, first data at n+m
// [RULE11] loads only when all banks idle; controller waits set delay after
// [RULE12] extended bit 0 enables dll; enabling is followed by a dll reset
// [RULE13] self refresh entry stops dll; exit restarts and resets it
// [RULE14] extended bit 1 selects full or reduced drive strength
// [RULE15] bit 10 disables strobe complement; redundant complement needs bit 11
// [RULE16] extended bit 12 disables all data and strobe outputs
// [RULE17] extended bits 2 and 6 select 50, 75 or 150 ohm termination
// [RULE18] termination pin works only in active and power-down states
// [RULE19] controller keeps termination pin low eight clocks after enabling
// [RULE20] extended bits 3 to 5 give additive latency 0 to 4
// [RULE21] commands held additive latency; read latency al+cl, write one less
// [RULE22] controller writes zero to reserved extended bits
// [RULE23] bank pins select main or extended register during a load
// [RULE24] controller drives every main field on each reload
// [RULE25] termination applied only while pin high and field enabled
// [RULE26] field encodings follow the customary assignment
module ddr2_mode_register_config (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // command and address pins
    input  wire logic        cke,
    input  wire logic        cs_n,
    input  wire logic        ras_n,
    input  wire logic        cas_n,
    input  wire logic        we_n,
    input  wire logic [2:0]  ba,
    input  wire logic [13:0] addr,
    input  wire logic        term_pin,
    // device controls
    output logic             dll_enable,
    output logic             dll_reset,
    output logic             dll_locked,
    output logic             dll_frozen,
    output logic             test_mode,
    output logic             drive_reduced,
    output logic             strobe_comp_en,
    output logic             rdqs_comp_en,
    output logic             outputs_off,
    output logic [7:0]       term_ohms,
    output logic             rd_first_data,
    output logic             wr_first_data,
    output logic             auto_precharge
);
    // pins after synchronisation
    logic [22:0] pin_s;
    logic        cke_s, cs_s, ras_s, cas_s, we_s, term_s;
    logic [2:0]  ba_s;
    logic [13:0] addr_s;

    pin_sync #(.W(23)) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       ({cke, cs_n, ras_n, cas_n, we_n, term_pin, ba, addr}),
        .q       (pin_s)
    );
    assign {cke_s, cs_s, ras_s, cas_s, we_s, term_s, ba_s, addr_s} = pin_s;

    // command decode from clock-enable history and strobes
    function automatic ddr2_cfg_pkg::cmd_t decode(input logic kp, input logic k,
                                                  input logic [3:0] c, input logic a10);
        decode = ddr2_cfg_pkg::CMD_NONE;
        if (!kp && k) begin
            decode = ddr2_cfg_pkg::CMD_EXIT;
        end else if (kp && !k) begin
            decode = (c == 4'h1) ? ddr2_cfg_pkg::CMD_SRE : ddr2_cfg_pkg::CMD_PDE;
        end else if (kp && !c[3]) begin
            unique case (c[2:0])
                3'h0: decode = ddr2_cfg_pkg::CMD_LOAD;
                3'h1: decode = ddr2_cfg_pkg::CMD_REF;
                3'h2: decode = ddr2_cfg_pkg::CMD_PRE;
                3'h3: decode = ddr2_cfg_pkg::CMD_ACT;
                3'h4: decode = a10 ? ddr2_cfg_pkg::CMD_WRA : ddr2_cfg_pkg::CMD_WR;
                3'h5: decode = a10 ? ddr2_cfg_pkg::CMD_RDA : ddr2_cfg_pkg::CMD_RD;
                default: decode = ddr2_cfg_pkg::CMD_NONE;
            endcase
        end
    endfunction

    // tap of a latency line: a delay of n clocks reads index n-2
    function automatic logic pick(input logic [31:0] sr, input logic [4:0] n);
        pick = (n < 5'd2) ? 1'b0 : sr[n - 5'd2];
    endfunction

    // termination code to effective ohms, zero when off
    function automatic logic [7:0] trm_ohms(input logic [1:0] code);
        unique case (code)
            2'h0: trm_ohms = 8'h00;
            2'h1: trm_ohms = 8'h4b;
            2'h2: trm_ohms = 8'h96;
            2'h3: trm_ohms = 8'h32;
        endcase
    endfunction

    // state
    logic                 cke_prev_q;
    logic [13:0]          mode_q, mode_d;
    logic [13:0]          ext1_q, ext1_d;
    logic [13:0]          ext2_q, ext2_d;
    logic [13:0]          ext3_q, ext3_d;
    ddr2_cfg_pkg::pwr_t   pwr_q, pwr_d;
    logic [7:0]           bank_open_q, bank_open_d;
    logic [7:0]           lock_cnt_q, lock_cnt_d;
    logic [31:0]          rd_sr_q, rd_sr_d;
    logic [31:0]          wr_sr_q, wr_sr_d;
    logic [31:0]          ap_sr_q, ap_sr_d;
    logic                 ctrl_accept_q, ctrl_accept_d;
    logic [31:0]          prdata_q, prdata_d;
    logic                 pready_q, pready_d;
    logic                 pslverr_q, pslverr_d;
    logic                 dll_en_q, dll_rst_q, locked_q, frozen_q;
    logic                 dll_en_d, dll_rst_d, locked_d, frozen_d;
    logic                 drv_q, dqsn_q, rdqs_q, qoff_q;
    logic [7:0]           ohms_q, ohms_d;
    logic                 rd_first_q, wr_first_q, ap_q;
    ddr2_cfg_pkg::cmd_t   cmd;
    logic                 load_ok, is_rd, is_wr, is_wra;
    logic [4:0]           cl, al, rl, wl, wr, bl_clk, ap_dly;

    // decoded command and derived latencies
    always_comb begin
        cmd     = decode(cke_prev_q, cke_s, {cs_s, ras_s, cas_s, we_s}, addr_s[10]);
        load_ok = (cmd == ddr2_cfg_pkg::CMD_LOAD) && ctrl_accept_q;
        is_rd   = (cmd == ddr2_cfg_pkg::CMD_RD) || (cmd == ddr2_cfg_pkg::CMD_RDA);
        is_wra  = (cmd == ddr2_cfg_pkg::CMD_WRA);
        is_wr   = (cmd == ddr2_cfg_pkg::CMD_WR) || is_wra;
        // [RULE9] cas latency decode
        cl = {2'h0, mode_q[`CL_LSB +: 3]};
        if (cl < 5'd3) begin
            cl = 5'd3; // codes below 3 fall back to the shortest
        end
        // [RULE20] additive latency decode
        al = {2'h0, ext1_q[`AL_LSB +: 3]};
        if (al > 5'd4) begin
            al = 5'd4;
        end
        // [RULE21] read and write latency
        rl = al + cl;
        wl = rl - 5'd1;
        // [RULE26] write recovery code n means n+1 clocks
        wr     = {2'h0, mode_q[`WR_LSB +: 3]} + 5'd1;
        bl_clk = (mode_q[`BL_LSB +: 3] == 3'h3) ? 5'd4 : 5'd2;
        ap_dly = wl + bl_clk + wr;
    end

    // mode and extended register loads
    always_comb begin
        mode_d = mode_q;
        ext1_d = ext1_q;
        ext2_d = ext2_q;
        ext3_d = ext3_q;
        dll_rst_d = 1'b0;
        if (load_ok) begin
            // [RULE23] bank pins pick the target register
            unique case (ba_s)
                3'h0: begin
                    if (addr_s[`TM_BIT]) begin
                        // [RULE1] test mode keeps the other fields
                        mode_d[`TM_BIT] = 1'b1;
                    end else begin
                        // [RULE2] dll reset pulses, bit never stored
                        mode_d = addr_s;
                        mode_d[`DLLR_BIT] = 1'b0;
                        dll_rst_d = addr_s[`DLLR_BIT];
                    end
                end
                3'h1: ext1_d = addr_s;
                3'h2: ext2_d = addr_s;
                3'h3: ext3_d = addr_s;
                default: ;
            endcase
        end
        // [RULE13] self refresh exit resets the dll
        if (pwr_q == ddr2_cfg_pkg::PWR_SELF_REF && cmd == ddr2_cfg_pkg::CMD_EXIT) begin
            dll_rst_d = 1'b1;
        end
    end

    // power state and open banks
    always_comb begin
        pwr_d = pwr_q;
        bank_open_d = bank_open_q;
        unique case (pwr_q)
            ddr2_cfg_pkg::PWR_ACTIVE: begin
                if (cmd == ddr2_cfg_pkg::CMD_SRE) begin
                    pwr_d = ddr2_cfg_pkg::PWR_SELF_REF;
                end else if (cmd == ddr2_cfg_pkg::CMD_PDE) begin
                    pwr_d = (|bank_open_q) ? ddr2_cfg_pkg::PWR_ACT_PD : ddr2_cfg_pkg::PWR_PRE_PD;
                end
            end
            ddr2_cfg_pkg::PWR_ACT_PD,
            ddr2_cfg_pkg::PWR_PRE_PD,
            ddr2_cfg_pkg::PWR_SELF_REF: begin
                if (cmd == ddr2_cfg_pkg::CMD_EXIT) begin
                    pwr_d = ddr2_cfg_pkg::PWR_ACTIVE;
                end
            end
        endcase
        if (cmd == ddr2_cfg_pkg::CMD_ACT) begin
            bank_open_d[ba_s] = 1'b1;
        end else if (cmd == ddr2_cfg_pkg::CMD_PRE && addr_s[10]) begin
            bank_open_d = 8'h00;
        end else if (cmd == ddr2_cfg_pkg::CMD_PRE || is_wra || cmd == ddr2_cfg_pkg::CMD_RDA) begin
            bank_open_d[ba_s] = 1'b0;
        end
    end

    // dll state: enable, lock counting, freeze
    always_comb begin
        // [RULE12] extended bit 0 low enables the dll
        // [RULE13] and self refresh stops it
        dll_en_d = !ext1_q[`DLL_BIT] && (pwr_q != ddr2_cfg_pkg::PWR_SELF_REF);
        lock_cnt_d = lock_cnt_q;
        if (dll_rst_q || !dll_en_q) begin
            lock_cnt_d = 8'h00;
        end else if (lock_cnt_q != `DLL_LOCK_CLKS) begin
            lock_cnt_d = lock_cnt_q + 8'h01;
        end
        // status only; read timing after reset is the controller's duty
        locked_d = dll_en_q && (lock_cnt_q == `DLL_LOCK_CLKS);
        // [RULE7] [RULE8] slow exit freezes the dll in active power-down
        frozen_d = (pwr_q == ddr2_cfg_pkg::PWR_ACT_PD) && mode_q[`PD_BIT];
    end

    // termination from pin, power state and extended field
    always_comb begin
        // [RULE17] [RULE18] [RULE25] termination gated by pin and state
        ohms_d = 8'h00;
        if (term_s && pwr_q != ddr2_cfg_pkg::PWR_SELF_REF) begin
            ohms_d = trm_ohms({ext1_q[`TRM1_BIT], ext1_q[`TRM0_BIT]});
        end
    end

    // latency lines for read, write and auto precharge
    always_comb begin
        // [RULE10] [RULE21] commands posted, taps pick the latency
        rd_sr_d = {rd_sr_q[30:0], is_rd};
        wr_sr_d = {wr_sr_q[30:0], is_wr};
        // [RULE4] precharge after last data plus write recovery
        ap_sr_d = {ap_sr_q[30:0], is_wra};
    end

    // apb slave: one wait state, answer registered
    always_comb begin
        pready_d = psel && penable && !pready_q;
        pslverr_d = 1'b0;
        prdata_d = prdata_q;
        ctrl_accept_d = ctrl_accept_q;
        if (psel && penable && !pready_q) begin
            pslverr_d = 1'b0;
            unique case (paddr)
                `OFF_MODE: prdata_d = {18'h0, mode_q};
                `OFF_EXT1: prdata_d = {18'h0, ext1_q};
                `OFF_EXT2: prdata_d = {18'h0, ext2_q};
                `OFF_EXT3: prdata_d = {18'h0, ext3_q};
                `OFF_STAT: prdata_d = {11'h0, wl, 3'h0, rl, 3'h0, frozen_q, mode_q[`TM_BIT],
                                       pwr_q == ddr2_cfg_pkg::PWR_SELF_REF, locked_q, dll_en_q};
                `OFF_CTRL: prdata_d = {31'h0, ctrl_accept_q};
                default: begin
                    prdata_d = 32'h0000_0000;
                    pslverr_d = 1'b1;
                end
            endcase
        end
        // write lands on the edge that samples pready high
        if (psel && penable && pready_q && pwrite && paddr == `OFF_CTRL) begin
            ctrl_accept_d = pwdata[0];
        end
    end

    // registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cke_prev_q    <= 1'b0;
            mode_q        <= `MODE_RST;
            ext1_q        <= `EXT_RST;
            ext2_q        <= `EXT_RST;
            ext3_q        <= `EXT_RST;
            pwr_q         <= ddr2_cfg_pkg::PWR_ACTIVE;
            bank_open_q   <= 8'h00;
            lock_cnt_q    <= 8'h00;
            rd_sr_q       <= 32'h0000_0000;
            wr_sr_q       <= 32'h0000_0000;
            ap_sr_q       <= 32'h0000_0000;
            ctrl_accept_q <= `CTRL_RST;
            prdata_q      <= 32'h0000_0000;
            pready_q      <= 1'b0;
            pslverr_q     <= 1'b0;
            dll_en_q      <= 1'b0;
            dll_rst_q     <= 1'b0;
            locked_q      <= 1'b0;
            frozen_q      <= 1'b0;
            drv_q         <= 1'b0;
            dqsn_q        <= 1'b0;
            rdqs_q        <= 1'b0;
            qoff_q        <= 1'b0;
            ohms_q        <= 8'h00;
            rd_first_q    <= 1'b0;
            wr_first_q    <= 1'b0;
            ap_q          <= 1'b0;
        end else begin
            cke_prev_q    <= cke_s;
            mode_q        <= mode_d;
            ext1_q        <= ext1_d;
            ext2_q        <= ext2_d;
            ext3_q        <= ext3_d;
            pwr_q         <= pwr_d;
            bank_open_q   <= bank_open_d;
            lock_cnt_q    <= lock_cnt_d;
            rd_sr_q       <= rd_sr_d;
            wr_sr_q       <= wr_sr_d;
            ap_sr_q       <= ap_sr_d;
            ctrl_accept_q <= ctrl_accept_d;
            prdata_q      <= prdata_d;
            pready_q      <= pready_d;
            pslverr_q     <= pslverr_d;
            dll_en_q      <= dll_en_d;
            dll_rst_q     <= dll_rst_d;
            locked_q      <= locked_d;
            frozen_q      <= frozen_d;
            // [RULE14] drive strength
            drv_q         <= ext1_q[`DRV_BIT];
            // [RULE15] [RULE16] strobe complements, all off when outputs off
            dqsn_q        <= !ext1_q[`DQSN_BIT] && !ext1_q[`QOFF_BIT];
            rdqs_q        <= ext1_q[`RDQS_BIT] && !ext1_q[`DQSN_BIT] && !ext1_q[`QOFF_BIT];
            qoff_q        <= ext1_q[`QOFF_BIT];
            ohms_q        <= ohms_d;
            rd_first_q    <= pick(rd_sr_q, rl);
            wr_first_q    <= pick(wr_sr_q, wl);
            ap_q          <= pick(ap_sr_q, ap_dly);
        end
    end

    // outputs straight from flops
    assign prdata         = prdata_q;
    assign pready         = pready_q;
    assign pslverr        = pslverr_q;
    assign dll_enable     = dll_en_q;
    assign dll_reset      = dll_rst_q;
    assign dll_locked     = locked_q;
    assign dll_frozen     = frozen_q;
    assign test_mode      = mode_q[`TM_BIT];
    assign drive_reduced  = drv_q;
    assign strobe_comp_en = dqsn_q;
    assign rdqs_comp_en   = rdqs_q;
    assign outputs_off    = qoff_q;
    assign term_ohms      = ohms_q;
    assign rd_first_data  = rd_first_q;
    assign wr_first_data  = wr_first_q;
    assign auto_precharge = ap_q;

    // checks on the block's own behaviour
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_main_load;
        load_ok && ba_s == 3'h0;
    endsequence
    sequence s_ext_load_drv;
        load_ok && ba_s == 3'h1 && addr_s[`DRV_BIT];
    endsequence
    sequence s_sr_exit;
        pwr_q == ddr2_cfg_pkg::PWR_SELF_REF && cmd == ddr2_cfg_pkg::CMD_EXIT;
    endsequence

    a_test_keeps_fields: assert property (s_main_load ##0 addr_s[`TM_BIT] |=> // RULE1
        $stable(mode_q[6:0]) && $stable(mode_q[13:8]) && mode_q[`TM_BIT])
        else $error("test mode load changed other fields");
    a_dll_reset_pulse: assert property (s_main_load ##0 (addr_s[8:7] == 2'h2) |=> // RULE2
        dll_reset && !mode_q[`DLLR_BIT] ##1 !dll_reset)
        else $error("dll reset not a self-clearing pulse");
    a_ap_wr_delay: assert property (is_wra && ap_dly == 5'd13 |-> ##13 auto_precharge) // RULE4
        else $error("auto precharge not at write recovery delay");
    a_fast_exit_run: assert property (pwr_q == ddr2_cfg_pkg::PWR_ACT_PD && !mode_q[`PD_BIT] |=> // RULE7
        !dll_frozen)
        else $error("dll frozen in fast-exit power-down");
    a_slow_exit_freeze: assert property (pwr_q == ddr2_cfg_pkg::PWR_ACT_PD && mode_q[`PD_BIT] |=> // RULE8
        dll_frozen)
        else $error("dll not frozen in slow-exit power-down");
    a_read_cl3: assert property (is_rd && rl == 5'd3 |-> ##3 rd_first_data) // RULE10
        else $error("first read data not at n+cl");
    a_write_lat: assert property (is_wr && wl == 5'd4 |=> !wr_first_data[*3] ##1 wr_first_data) // RULE21
        else $error("write latency not read latency minus one");
    a_sr_dll_off: assert property (pwr_q == ddr2_cfg_pkg::PWR_SELF_REF |=> !dll_enable) // RULE13
        else $error("dll enabled in self refresh");
    a_sr_exit_reset: assert property (s_sr_exit |=> dll_reset) // RULE13
        else $error("no dll reset on self refresh exit");
    a_drive_follow: assert property (s_ext_load_drv |-> ##2 drive_reduced) // RULE14
        else $error("reduced drive not applied");
    a_outputs_off: assert property (outputs_off |-> !strobe_comp_en && !rdqs_comp_en) // RULE16
        else $error("strobe complement active with outputs off");
    a_term_self_ref: assert property (pwr_q == ddr2_cfg_pkg::PWR_SELF_REF |=> term_ohms == 8'h00) // RULE18
        else $error("termination on in self refresh");
    a_term_pin_low: assert property (!term_s |=> term_ohms == 8'h00) // RULE25
        else $error("termination on with pin low");
endmodule

// [tb/ddr2_ctrl_model.sv]
`timescale 1ns/1ns
// controller behind the command pins
module ddr2_ctrl_model #(
    parameter int MRD = 6
) (
    // clock
    input  wire logic   pclk,
    // command and address pins
    output logic        cke,
    output logic        cs_n,
    output logic        ras_n,
    output logic        cas_n,
    output logic        we_n,
    output logic [2:0]  ba,
    output logic [13:0] addr,
    output logic        term_pin
);
    time t_rst;

    // deselected, clock disabled, termination off until the bench starts
    initial begin
        cke = 0;
        {cs_n, ras_n, cas_n, we_n} = 4'hf;
        ba = 3'h0;
        addr = 14'h0;
        term_pin = 0;
        t_rst = 0;
    end

    // one command then nop; released lines show the inverse so stale values cannot pass
    task automatic send(input logic [3:0] c, input logic [2:0] b, input logic [13:0] a, input logic k);
        @(posedge pclk);
        while (c == 4'h5 && $time - t_rst < 200 * 100) @(posedge pclk);
        {cs_n, ras_n, cas_n, we_n} <= c;
        ba <= b;
        addr <= a;
        cke <= k;
        if (c == 4'h0 && b == 3'h0 && a[8] && !a[7]) t_rst = $time;
        @(posedge pclk);
        {cs_n, ras_n, cas_n, we_n} <= 4'h7;
        ba <= ~b;
        addr <= ~a;
        if (c == 4'h0) repeat (MRD) @(posedge pclk);
    endtask
endmodule

// [tb/ddr2_mode_register_config_tb_top.sv]
`timescale 1ns/1ns
// apb access plus pin traffic from the controller model
module ddr2_mode_register_config_tb_top;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic [7:0]  paddr, term_ohms;
    logic [31:0] pwdata, prdata, rd;
    logic        cke, cs_n, ras_n, cas_n, we_n, term_pin, dll_enable, dll_reset, dll_locked, dll_frozen;
    logic        test_mode, drive_reduced, strobe_comp_en, rdqs_comp_en, outputs_off;
    logic        rd_first_data, wr_first_data, auto_precharge;
    logic [2:0]  ba, pul;
    logic [13:0] addr;
    int          fails, tests_run, nrst, n, cl, al;
    int          ohm[4] = '{0, 75, 150, 50};
    localparam int WRC = (450 + 99) / 100;

    ddr2_mode_register_config dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .cke, .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr, .term_pin, .dll_enable, .dll_reset, .dll_locked,
        .dll_frozen, .test_mode, .drive_reduced, .strobe_comp_en, .rdqs_comp_en, .outputs_off, .term_ohms,
        .rd_first_data, .wr_first_data, .auto_precharge);
    ddr2_ctrl_model m (.pclk, .cke, .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr, .term_pin);
    assign pul = {auto_precharge, wr_first_data, rd_first_data};

    // clock
    initial begin
        pclk = 0;
        forever #50 pclk = ~pclk;
    end
    // dll reset pulses seen so far
    always @(posedge pclk) if (dll_reset === 1'b1) nrst++;

    task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
        tests_run++;
        if (g !== x) begin
            fails++;
            $display("mismatch %s expected %h seen %h", s, x, g);
        end
    endtask
    // apb transfer held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        n = 0;
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk) penable <= 1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) fails++;
        rd = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask
    task automatic ld(input logic [2:0] b, input logic [13:0] w);
        m.send(4'h0, b, w, 1);
    endtask
    // edges from command drive to a pulse, bounded
    task automatic lat(input int s, input int x, input string w);
        n = 1;
        do begin
            @(posedge pclk);
            n++;
        end while (pul[s] !== 1'b1 && n < 80);
        chk(w, x, n);
    endtask
    function automatic logic [13:0] mw(input int pd, wr, dr, c, bl);
        return {1'b0, pd[0], wr[2:0], dr[0], 1'b0, c[2:0], 1'b0, bl[2:0]};
    endfunction
    function automatic logic [13:0] ew(input int qo, rq, dn, t, a, dv);
        return {1'b0, qo[0], rq[0], dn[0], 3'h0, t[1], a[2:0], t[0], dv[0], 1'b0};
    endfunction
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // watchdog well beyond the expected fifteen hundred or so clocks
    initial begin
        #2000000;
        fails++;
        report_and_stop;
    end

    initial begin
        presetn = 0;
        psel = 0;
        penable = 0;
        pwrite = 0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (20) @(posedge pclk);
        presetn <= 1;
        repeat (3) @(posedge pclk);
        m.send(4'h7, 3'h0, 14'h0, 1);
        // reset state, read-only word, unmapped offset
        apb(0, 8'h14, 0);
        chk("ctrl", 1, rd);
        apb(1, 8'h00, 32'h1fff);
        apb(0, 8'h00, 0);
        chk("main ro", 0, rd);
        apb(0, 8'h18, 0);
        chk("unmapped", 32'h8000_0000, {e, rd[30:0]});
        chk("dll on", 1, dll_enable);
        $display("test reset done");
        // cas latency 3 to 6, additive latency 0 to 4: status, self-clearing reset bit, read timing
        for (int i = 0; i < 5; i++) begin
            cl = (i == 4) ? 3 : 3 + i;
            al = i;
            ld(3'h1, ew(0, 0, 0, 0, al, 0));
            ld(3'h0, mw(0, WRC - 1, 1, cl, 2));
            apb(0, 8'h00, 0);
            chk("main", mw(0, WRC - 1, 0, cl, 2), rd);
            apb(0, 8'h10, 0);
            chk("rl", al + cl, rd[12:8]);
            chk("wl", al + cl - 1, rd[20:16]);
            m.send(4'h3, 3'h0, 14'h0, 1);
            m.send(4'h5, 3'h0, 14'h400, 1);
            lat(0, 3 + al + cl, "read");
            chk("locked", 1, dll_locked);
        end
        chk("resets", 5, nrst);
        $display("test latency done");
        // burst of eight, write latency, precharge after recovery
        ld(3'h1, ew(0, 0, 0, 0, 1, 0));
        ld(3'h0, mw(0, WRC - 1, 0, 4, 3));
        for (int s = 1; s < 3; s++) begin
            m.send(4'h3, 3'h0, 14'h0, 1);
            m.send(4'h4, 3'h0, 14'h400, 1);
            lat(s, (s == 1) ? 7 : 11 + WRC, "write");
            repeat (10) @(posedge pclk); // let the earlier precharge pulse pass
        end
        $display("test write done");
        // test bit keeps other fields, no reset fired
        ld(3'h0, mw(1, 0, 1, 6, 2) | 14'h0080);
        chk("test on", 1, test_mode);
        apb(0, 8'h00, 0);
        chk("main kept", mw(0, WRC - 1, 0, 4, 3) | 14'h0080, rd);
        ld(3'h0, mw(1, WRC - 1, 0, 4, 3));
        chk("test off", 0, test_mode);
        chk("no reset", 5, nrst);
        $display("test mode done");
        // each strobe, output and termination code
        for (int j = 0; j < 8; j++) begin
            ld(3'h1, ew(j >> 2, j >> 1, j, j, 0, j));
            apb(0, 8'h04, 0);
            chk("ext1", ew(j >> 2, j >> 1, j, j, 0, j), rd);
            chk("drive", j & 1, drive_reduced);
            chk("strobe", !j[0] && !j[2], strobe_comp_en);
            chk("rdqs", j == 2, rdqs_comp_en);
            chk("off", j >> 2, outputs_off);
            chk("term low", 0, term_ohms);
            repeat (8) @(posedge pclk);
            m.term_pin <= 1;
            repeat (5) @(posedge pclk);
            chk("term", ohm[j & 3], term_ohms);
            m.term_pin <= 0;
        end
        $display("test ext done");
        // accept bit clear drops loads
        apb(1, 8'h14, 0);
        ld(3'h0, 14'h0);
        apb(0, 8'h00, 0);
        chk("ignored", mw(1, WRC - 1, 0, 4, 3), rd);
        apb(1, 8'h14, 1);
        // slow exit set: open bank, power down, dll frozen
        m.send(4'h3, 3'h0, 14'h0, 1);
        m.send(4'h7, 3'h0, 14'h0, 0);
        repeat (4) @(posedge pclk);
        chk("frozen", 1, dll_frozen);
        m.send(4'h7, 3'h0, 14'h0, 1);
        m.send(4'h2, 3'h0, 14'h400, 1);
        m.send(4'h1, 3'h0, 14'h0, 0);
        repeat (4) @(posedge pclk);
        chk("sr dll", 0, dll_enable);
        m.send(4'h7, 3'h0, 14'h0, 1);
        repeat (6) @(posedge pclk);
        chk("sr exit", 6, nrst);
        chk("dll back", 1, dll_enable);
        $display("test refresh done");
        report_and_stop;
    end
endmodule
